// file: rtl/dfa_pkg.sv
package dfa_pkg;

    // bus geometry
    localparam int             DFA_ADDR_W      = 12;
    localparam int             DFA_DATA_W      = 32;

    // register byte addresses
    localparam logic [11:0]    DFA_CTRL_ADDR   = 12'h000;
    localparam logic [11:0]    DFA_STAT_ADDR   = 12'h004;
    // option byte keeps its printed offset as an index, one word per index
    localparam logic [11:0]    DFA_OPT_INDEX   = 12'h0C2;
    localparam logic [11:0]    DFA_OPT_ADDR    = {DFA_OPT_INDEX[9:0], 2'b00};

    // data_flash_control fields
    localparam int             DFA_EN_BIT      = 0;
    localparam logic           DFA_EN_RESET    = 1'b0;

    // status fields
    localparam int             DFA_ST_READY    = 0;
    localparam int             DFA_ST_SETUP    = 1;
    localparam int             DFA_ST_STOPPED  = 2;
    localparam int             DFA_ST_MODE_LO  = 4;
    localparam int             DFA_ST_MODE_HI  = 5;

    // flash_clock_config_byte fields
    localparam int             DFA_MODE_HI_BIT = 7;
    localparam int             DFA_MODE_LO_BIT = 6;
    localparam logic [7:0]     DFA_OPT_RESET   = 8'h00;

    // flash operation mode codes {flash_op_mode_hi, flash_op_mode_lo}
    localparam logic [1:0]     DFA_MODE_LV     = 2'h0;
    localparam logic [1:0]     DFA_MODE_LS     = 2'h2;
    localparam logic [1:0]     DFA_MODE_HS     = 2'h3;

    // timing
    localparam int             DFA_CLK_MHZ     = 10;
    localparam int             DFA_SETUP_HS_NS = 5000;
    localparam int             DFA_SETUP_LS_NS = 720;
    localparam int             DFA_SETUP_LV_NS = 10000;
    localparam int             DFA_CNT_W       = 8;
    // least times, so rounded up to whole cycles
    localparam logic [7:0]     DFA_SETUP_HS_CYC =
        8'((DFA_SETUP_HS_NS * DFA_CLK_MHZ + 999) / 1000);
    localparam logic [7:0]     DFA_SETUP_LS_CYC =
        8'((DFA_SETUP_LS_NS * DFA_CLK_MHZ + 999) / 1000);
    localparam logic [7:0]     DFA_SETUP_LV_CYC =
        8'((DFA_SETUP_LV_NS * DFA_CLK_MHZ + 999) / 1000);

    // axi responses
    localparam logic [1:0]     DFA_RESP_OKAY   = 2'h0;
    localparam logic [1:0]     DFA_RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        DFA_STOPPED = 3'h1,
        DFA_SETUP   = 3'h2,
        DFA_READY   = 3'h4
    } dfa_state_t;

endpackage : dfa_pkg

// file: rtl/dfa_setup_timer.sv
`timescale 1ns/1ps
module dfa_setup_timer
    import dfa_pkg::*;
#(
    parameter int CNT_W = DFA_CNT_W
)
(
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             start,
    input  wire logic             abort,
    input  wire logic [CNT_W-1:0] load,
    output logic                  busy,
    output logic                  done
);

    // a one-bit counter cannot tell a loaded count from its last cycle
    if (CNT_W < 2)
    begin : g_cnt_w_check
        $error("dfa_setup_timer: CNT_W too small");
    end

    logic [CNT_W-1:0] count;
    wire              last = busy && (count == CNT_W'(1));

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            count <= '0;
            busy  <= 1'b0;
            done  <= 1'b0;
        end
        else if (abort)
        begin
            // abort wins so a later start always runs the full count
            count <= '0;
            busy  <= 1'b0;
            done  <= 1'b0;
        end
        else if (start)
        begin
            count <= load;
            busy  <= 1'b1;
            done  <= 1'b0;
        end
        else
        begin
            count <= busy ? count - CNT_W'(1) : count;
            busy  <= busy && !last;
            done  <= last;
        end
    end

endmodule : dfa_setup_timer

// file: rtl/dfa_top.sv
`timescale 1ns/1ps
// What this block does
// - after reset data flash stays stopped
// - setup wait per mode: 5us, 720ns, 10us
// - no read or program during setup
// - after setup, CPU reads are allowed
module dfa_top
    import dfa_pkg::*;
(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // axi4-lite slave
    input  wire logic [DFA_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]            s_axi_awprot,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [DFA_DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [DFA_ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]            s_axi_arprot,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [DFA_DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // option byte as loaded from the flash, not on aclk
    input  wire logic [7:0]            option_byte_in,
    // cpu side, same clock
    input  wire logic                  flash_read_req,
    input  wire logic                  flash_program_req,
    input  wire logic                  stop_req,
    output logic                       flash_read_grant,
    output logic                       flash_program_grant,
    output logic                       stop_permit,
    output logic                       flash_powered,
    output logic                       flash_ready
);

    // option byte synchroniser
    logic [7:0] opt_meta;
    logic [7:0] opt_sync;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            opt_meta <= DFA_OPT_RESET;
            opt_sync <= DFA_OPT_RESET;
        end
        else
        begin
            opt_meta <= option_byte_in;
            opt_sync <= opt_meta;
        end
    end

    wire [1:0] op_mode = {opt_sync[DFA_MODE_HI_BIT],
                          opt_sync[DFA_MODE_LO_BIT]};
    // a prohibited code gets the longest wait, safest guess
    wire [DFA_CNT_W-1:0] setup_load =
        (op_mode == DFA_MODE_HS) ? DFA_SETUP_HS_CYC :
        (op_mode == DFA_MODE_LS) ? DFA_SETUP_LS_CYC :
                                   DFA_SETUP_LV_CYC;

    // axi write path
    logic                  aw_full;
    logic                  w_full;
    logic [DFA_ADDR_W-1:0] aw_addr;
    logic [DFA_DATA_W-1:0] w_data;
    logic [3:0]            w_strb;

    wire aw_take   = s_axi_awvalid && s_axi_awready;
    wire w_take    = s_axi_wvalid && s_axi_wready;
    wire wr_fire   = aw_full && w_full && !s_axi_bvalid;
    wire wr_ctrl   = aw_addr == DFA_CTRL_ADDR;
    wire wr_known  = wr_ctrl || aw_addr == DFA_STAT_ADDR
                     || aw_addr == DFA_OPT_ADDR;
    wire ctrl_wr   = wr_fire && wr_ctrl && w_strb[0];
    wire ctrl_bit  = w_data[DFA_EN_BIT];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= DFA_RESP_OKAY;
            aw_full       <= 1'b0;
            w_full        <= 1'b0;
            aw_addr       <= '0;
            w_data        <= '0;
            w_strb        <= '0;
        end
        else
        begin
            if (aw_take)
            begin
                aw_addr       <= s_axi_awaddr;
                aw_full       <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (w_take)
            begin
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                w_full       <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire)
            begin
                aw_full      <= 1'b0;
                w_full       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? DFA_RESP_OKAY : DFA_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // enable bit and setup sequencing
    logic       data_flash_enable;
    dfa_state_t state;
    dfa_state_t next_state;
    logic       timer_busy;
    logic       timer_done;

    wire en_rise  = ctrl_wr && ctrl_bit && !data_flash_enable;
    wire en_clear = ctrl_wr && !ctrl_bit;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            data_flash_enable <= DFA_EN_RESET;
        else if (ctrl_wr)
            data_flash_enable <= ctrl_bit;
    end

    dfa_setup_timer #(
        .CNT_W (DFA_CNT_W)
    ) u_setup_timer (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   (en_rise),
        .abort   (en_clear),
        .load    (setup_load),
        .busy    (timer_busy),
        .done    (timer_done)
    );

    always_comb
    begin
        next_state = state;
        case (state)
            DFA_STOPPED:
                if (en_rise)
                    next_state = DFA_SETUP;
            DFA_SETUP:
                if (en_clear)
                    next_state = DFA_STOPPED;
                else if (timer_done && !timer_busy)
                    next_state = DFA_READY;
            DFA_READY:
                if (en_clear)
                    next_state = DFA_STOPPED;
            default:
                next_state = DFA_STOPPED;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state <= DFA_STOPPED;
        else
            state <= next_state;
    end

    // cpu-side gating, registered so outputs come from flops
    wire is_ready = state == DFA_READY;
    wire is_setup = state == DFA_SETUP;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            flash_read_grant    <= 1'b0;
            flash_program_grant <= 1'b0;
            stop_permit         <= 1'b1;
            flash_powered       <= 1'b0;
            flash_ready         <= 1'b0;
        end
        else
        begin
            flash_read_grant    <= flash_read_req && is_ready;
            // program path is used by the rewrite library only
            flash_program_grant <= flash_program_req && is_ready;
            stop_permit         <= !is_setup;
            flash_powered       <= state != DFA_STOPPED;
            flash_ready         <= is_ready;
        end
    end

    // axi read path
    wire [DFA_DATA_W-1:0] stat_word = {
        {(DFA_DATA_W - DFA_ST_MODE_HI - 1){1'b0}},
        op_mode,
        1'b0,
        state == DFA_STOPPED,
        is_setup,
        is_ready
    };
    wire [DFA_DATA_W-1:0] ctrl_word = {
        {(DFA_DATA_W - 1){1'b0}},
        data_flash_enable
    };
    wire [DFA_DATA_W-1:0] opt_word = {{(DFA_DATA_W - 8){1'b0}}, opt_sync};

    wire rd_ctrl  = s_axi_araddr == DFA_CTRL_ADDR;
    wire rd_stat  = s_axi_araddr == DFA_STAT_ADDR;
    wire rd_opt   = s_axi_araddr == DFA_OPT_ADDR;
    wire rd_known = rd_ctrl || rd_stat || rd_opt;
    wire [DFA_DATA_W-1:0] rd_word =
        rd_ctrl ? ctrl_word :
        rd_stat ? stat_word :
        rd_opt  ? opt_word  : '0;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= DFA_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_known ? DFA_RESP_OKAY : DFA_RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule : dfa_top

// file: verif/dfa_top_monitor.sv
`timescale 1ns/1ps
module dfa_top_monitor
    import dfa_pkg::*;
(
    input wire logic                  aclk,
    input wire logic                  aresetn,
    input wire logic                  s_axi_awvalid,
    input wire logic                  s_axi_awready,
    input wire logic                  s_axi_wvalid,
    input wire logic                  s_axi_wready,
    input wire logic                  s_axi_bvalid,
    input wire logic                  s_axi_arvalid,
    input wire logic                  s_axi_arready,
    input wire logic                  s_axi_rvalid,
    input wire logic [7:0]            option_byte_in,
    input wire logic                  flash_read_req,
    input wire logic                  flash_program_req,
    input wire logic                  flash_read_grant,
    input wire logic                  flash_program_grant,
    input wire logic                  stop_permit,
    input wire logic                  flash_powered,
    input wire logic                  flash_ready
);
    logic [7:0] cnt;
    wire  [7:0] n1;

    // powered-but-not-ready edges equal the setup count plus one
    assign n1 = option_byte_in[7:6] == 2'h3 ? 8'h33 :
                option_byte_in[7:6] == 2'h2 ? 8'h09 : 8'h65;

    always_ff @(posedge aclk)
        if (!aresetn || !flash_powered)
            cnt <= 8'h00;
        else if (!flash_ready)
            cnt <= cnt + 8'h01;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_read_gate: assert property (
        flash_read_grant |-> flash_ready && $past(flash_read_req))
        else $error("read grant outside ready");
    chk_prog_gate: assert property (
        flash_program_grant |-> flash_ready && $past(flash_program_req))
        else $error("program grant outside ready");
    chk_read_given: assert property (
        flash_read_req |=> flash_read_grant == flash_ready)
        else $error("read grant does not track ready");
    chk_prog_given: assert property (
        flash_program_req |=> flash_program_grant == flash_ready)
        else $error("program grant does not track ready");
    chk_setup_len: assert property (
        $rose(flash_ready) |-> cnt == n1)
        else $error("setup interval length wrong");
    chk_stop_block: assert property (
        stop_permit == !(flash_powered && !flash_ready))
        else $error("stop permit wrong during setup");
    chk_power_cause: assert property (
        $rose(flash_powered) |-> $past(s_axi_bvalid))
        else $error("flash powered without a write");
    chk_ready_power: assert property (
        flash_ready |-> flash_powered)
        else $error("ready while stopped");
    chk_read_lat: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    chk_write_lat: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid)
        else $error("write answer late");
endmodule : dfa_top_monitor

bind dfa_top dfa_top_monitor dfa_top_monitor_inst (.*);

// file: verif/dfa_cpu_model.sv
`timescale 1ns/1ps
module dfa_cpu_model
(
    input  wire logic aclk,
    input  wire logic flash_read_grant,
    input  wire logic flash_program_grant,
    output logic      flash_read_req,
    output logic      flash_program_req
);
    logic dma_wait;

    initial
    begin
        flash_read_req    = 1'b0;
        flash_program_req = 1'b0;
        dma_wait          = 1'b0;
    end

    task automatic access(input logic prog, output logic grant);
        dma_wait <= 1'b1;
        repeat (3) @(posedge aclk);
        // oscillator restart settle before a rewrite
        if (prog)
            repeat (300) @(posedge aclk);
        @(posedge aclk);
        flash_read_req    <= !prog;
        flash_program_req <= prog;
        repeat (2) @(posedge aclk);
        grant = prog ? flash_program_grant : flash_read_grant;
        flash_read_req    <= 1'b0;
        flash_program_req <= 1'b0;
        dma_wait          <= 1'b0;
    endtask : access
endmodule : dfa_cpu_model

// file: verif/dfa_top_tb_top.sv
`timescale 1ns/1ps
module dfa_top_tb_top
    import dfa_pkg::*;
;
    logic        aclk, aresetn, stop_req, g, stop_permit;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0]  s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, flash_powered, flash_ready;
    logic [7:0]  option_byte_in;
    logic        flash_read_req, flash_program_req;
    logic        flash_read_grant, flash_program_grant;
    int          mismatches, checks, n;
    // last entry is a prohibited mode code, which gets the longest wait
    logic [7:0]  ob[4] = '{8'hE0, 8'hA0, 8'h20, 8'h60};
    int          ns[4] = '{5000, 720, 10000, 10000};

    dfa_top dfa_top_inst (.*);
    dfa_cpu_model dfa_cpu_model_inst (.aclk(aclk),
        .flash_read_grant(flash_read_grant),
        .flash_program_grant(flash_program_grant),
        .flash_read_req(flash_read_req),
        .flash_program_req(flash_program_req));

    always #50 aclk = ~aclk;

    task final_report;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    task check(input string nm, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task hang(input int k);
        if (k > 3000)
        begin
            mismatches++;
            final_report();
        end
    endtask : hang

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            k++;
            hang(k);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rdr(input logic [11:0] a);
        int k = 0;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            k++;
            hang(k);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rdr

    // edges from the write answer until ready is seen
    task wait_ready;
        n = 0;
        while (!flash_ready)
        begin
            @(posedge aclk);
            n++;
            hang(n);
            if (n == 2)
                check("stop_permit", stop_permit, 0);
        end
    endtask : wait_ready

    initial
    begin
        {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, stop_req, mismatches, checks} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
        s_axi_wdata    = '0;
        s_axi_wstrb    = 4'hF;
        option_byte_in = 8'hE0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rdr(DFA_CTRL_ADDR);
        check("ctrl", rd, 32'h0);
        rdr(DFA_STAT_ADDR);
        check("status", rd, 32'h34);
        rdr(DFA_OPT_ADDR);
        check("option", rd, 32'hE0);
        dfa_cpu_model_inst.access(1'b0, g);
        check("stopped read", g, 0);
        $display("test reset done");
        for (int i = 0; i < 4; i++)
        begin
            option_byte_in <= ob[i];
            repeat (4) @(posedge aclk);
            wr(DFA_CTRL_ADDR, 32'h1);
            check("enable resp", rs, DFA_RESP_OKAY);
            wait_ready();
            check("setup", n, (ns[i] + 99) / 100 + 2);
            dfa_cpu_model_inst.access(1'b0, g);
            check("ready read", g, 1);
            wr(DFA_CTRL_ADDR, 32'h0);
            dfa_cpu_model_inst.access(1'b0, g);
            check("off read", g, 0);
        end
        $display("test modes done");
        option_byte_in <= 8'hE0;
        repeat (4) @(posedge aclk);
        wr(DFA_CTRL_ADDR, 32'h1);
        dfa_cpu_model_inst.access(1'b0, g);
        check("setup read", g, 0);
        wr(DFA_CTRL_ADDR, 32'h0);
        repeat (2) @(posedge aclk);
        stop_req <= 1'b1;
        check("stop ok", stop_permit, 1);
        @(posedge aclk);
        stop_req <= 1'b0;
        wr(DFA_CTRL_ADDR, 32'h1);
        wait_ready();
        check("restart", n, 52);
        wr(DFA_CTRL_ADDR, 32'h1);
        // a wrongly restarted setup would drop ready two edges later
        repeat (3) @(posedge aclk);
        check("no restart", flash_ready, 1);
        dfa_cpu_model_inst.access(1'b1, g);
        check("program", g, 1);
        $display("test restart done");
        wr(12'h010, 32'h1);
        check("bad wr", rs, DFA_RESP_SLVERR);
        rdr(12'h010);
        check("bad rd", rd, 32'h0);
        check("bad rresp", rs, DFA_RESP_SLVERR);
        wr(DFA_STAT_ADDR, 32'h0);
        check("ro wr", rs, DFA_RESP_OKAY);
        repeat (3) @(posedge aclk);
        check("ro kept", flash_ready, 1);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rdr(DFA_CTRL_ADDR);
        check("rereset", {rd[0], flash_powered}, 2'b00);
        $display("test bus done");
        final_report();
    end
endmodule : dfa_top_tb_top
